// ### hdl/lcdext_pkg.sv
package lcdext_pkg;

    // ************************************************************
    // Register indices within the extension space
    // ************************************************************
    localparam logic [7:0] IDX_SYNC_POLARITY   = 8'h80;
    localparam logic [7:0] IDX_DISPLAY_MODE    = 8'h81;
    localparam logic [7:0] IDX_CHAR_CLOCK      = 8'h82;

    // ************************************************************
    // Implemented bit masks and reset values
    // ************************************************************
    localparam logic [7:0] MASK_SYNC_POLARITY  = 8'hF0;
    localparam logic [7:0] MASK_DISPLAY_MODE   = 8'hB9;
    localparam logic [7:0] MASK_CHAR_CLOCK     = 8'h0F;
    localparam logic [7:0] RST_SYNC_POLARITY   = 8'h00;
    localparam logic [7:0] RST_DISPLAY_MODE    = 8'h00;
    localparam logic [7:0] RST_CHAR_CLOCK      = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_VSYNC_POL      = 7;
    localparam int BIT_HSYNC_POL      = 6;
    localparam int BIT_POL_SOURCE     = 5;
    localparam int BIT_EXPAND_GFX     = 4;
    localparam int BIT_SIMUL_CRT_LCD  = 7;
    localparam int BIT_AUTOMAP        = 5;
    localparam int BIT_SINGLE_SCAN    = 4;
    localparam int BIT_COMPANION_MODE = 3;
    localparam int BIT_DISPLAY_TYPE   = 0;
    localparam int BIT_WIDTH_OVERRIDE = 3;

    // ************************************************************
    // Expansion ratio and character widths in dot clocks
    // ************************************************************
    localparam logic [4:0] EXPAND_SRC_LINES = 5'h10;
    localparam logic [4:0] EXPAND_DST_LINES = 5'h13;
    localparam logic [3:0] DOTS_CODE0       = 4'h9;
    localparam logic [3:0] DOTS_CODE1       = 4'h8;
    localparam logic [3:0] DOTS_CODE2       = 4'h4;
    localparam logic [3:0] DOTS_CODE4       = 4'hB;

endpackage : lcdext_pkg

// ### hdl/lcdext_control.sv
module lcdext_control
    import lcdext_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] index_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [1:0] misc_sync_pol_i,
    input  wire logic       sequencer_clocking_bit0_i,
    input  wire logic       gfx_mode_i,
    input  wire logic       scanline_i,
    output logic [7:0]      rdata_o,
    output logic            vsync_active_low_o,
    output logic            hsync_active_low_o,
    output logic            replicate_line_o,
    output logic            expand_enable_o,
    output logic            simultaneous_crt_lcd_o,
    output logic            automap_enable_o,
    output logic            single_scan_o,
    output logic            half_frame_enable_o,
    output logic            companion_mode_o,
    output logic            lcd_active_o,
    output logic [2:0]      char_width_code_o,
    output logic [3:0]      dots_per_char_o,
    output logic            char_width_reserved_o
);

    // ************************************************************
    // Register storage and next values
    // ************************************************************
    logic [7:0] sync_polarity_control;
    logic [7:0] display_mode_control;
    logic [7:0] char_clock_width_select;
    logic [4:0] line_phase;
    logic       scan_q;
    logic       scan_edge;
    logic       expand_active;
    logic [7:0] next_sync_polarity_control;
    logic [7:0] next_display_mode_control;
    logic [7:0] next_char_clock_width_select;
    logic [7:0] next_rdata;
    logic [4:0] next_line_phase;
    logic       next_replicate;
    logic       next_vsync_low;
    logic       next_hsync_low;
    logic       next_expand;
    logic       next_simultaneous;
    logic       next_automap;
    logic       next_single_scan;
    logic       next_half_frame;
    logic       next_companion;
    logic       next_lcd_active;
    logic [2:0] next_code;
    logic [3:0] next_dots;
    logic       next_reserved;

    // ************************************************************
    // Host register access
    // ************************************************************
    // Masked writes; a read in the same cycle still sees the old value
    always_comb begin
        next_sync_polarity_control   = sync_polarity_control;
        next_display_mode_control    = display_mode_control;
        next_char_clock_width_select = char_clock_width_select;
        if (wr_i) begin
            unique case (index_i)
                IDX_SYNC_POLARITY: begin
                    next_sync_polarity_control = wdata_i & MASK_SYNC_POLARITY;
                end
                IDX_DISPLAY_MODE: begin
                    next_display_mode_control = wdata_i & MASK_DISPLAY_MODE;
                end
                IDX_CHAR_CLOCK: begin
                    // Upper bits are dropped even if software leaves them set
                    next_char_clock_width_select = wdata_i & MASK_CHAR_CLOCK;
                end
                default: begin
                end
            endcase
        end
        // Unmapped indices and idle cycles return zero
        next_rdata = 8'h00;
        if (rd_i) begin
            unique case (index_i)
                IDX_SYNC_POLARITY: next_rdata = sync_polarity_control;
                IDX_DISPLAY_MODE:  next_rdata = display_mode_control;
                IDX_CHAR_CLOCK:    next_rdata = char_clock_width_select;
                default:           next_rdata = 8'h00;
            endcase
        end
    end

    // Host registers and read data
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync_polarity_control   <= RST_SYNC_POLARITY;
            display_mode_control    <= RST_DISPLAY_MODE;
            char_clock_width_select <= RST_CHAR_CLOCK;
            rdata_o                 <= 8'h00;
        end else begin
            sync_polarity_control   <= next_sync_polarity_control;
            display_mode_control    <= next_display_mode_control;
            char_clock_width_select <= next_char_clock_width_select;
            rdata_o                 <= next_rdata;
        end
    end

    // ************************************************************
    // Display control decode
    // ************************************************************
    // Sync polarity source, panel and CRT selects, width code and dots
    always_comb begin
        if (sync_polarity_control[BIT_POL_SOURCE]) begin
            next_vsync_low = sync_polarity_control[BIT_VSYNC_POL];
            next_hsync_low = sync_polarity_control[BIT_HSYNC_POL];
        end else begin
            next_vsync_low = misc_sync_pol_i[1];
            next_hsync_low = misc_sync_pol_i[0];
        end
        next_expand       = sync_polarity_control[BIT_EXPAND_GFX];
        next_simultaneous = display_mode_control[BIT_SIMUL_CRT_LCD];
        next_automap      = display_mode_control[BIT_AUTOMAP];
        next_single_scan  = display_mode_control[BIT_SINGLE_SCAN];
        next_half_frame   = ~display_mode_control[BIT_SINGLE_SCAN];
        next_companion    = display_mode_control[BIT_COMPANION_MODE];
        next_lcd_active   = display_mode_control[BIT_DISPLAY_TYPE];
        // Without the override, width bit 0 follows the sequencer
        next_code = char_clock_width_select[2:0];
        if (!char_clock_width_select[BIT_WIDTH_OVERRIDE]) begin
            next_code[0] = sequencer_clocking_bit0_i;
        end
        // Reserved codes fall back to 8 dots and raise a flag
        next_reserved = 1'b0;
        unique case (next_code)
            3'h0:    next_dots = DOTS_CODE0;
            3'h1:    next_dots = DOTS_CODE1;
            3'h2:    next_dots = DOTS_CODE2;
            3'h4:    next_dots = DOTS_CODE4;
            default: begin
                next_dots     = DOTS_CODE1;
                next_reserved = 1'b1;
            end
        endcase
    end

    // Registered control outputs
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            vsync_active_low_o     <= 1'b0;
            hsync_active_low_o     <= 1'b0;
            expand_enable_o        <= 1'b0;
            simultaneous_crt_lcd_o <= 1'b0;
            automap_enable_o       <= 1'b0;
            single_scan_o          <= 1'b0;
            half_frame_enable_o    <= 1'b0;
            companion_mode_o       <= 1'b0;
            lcd_active_o           <= 1'b0;
            char_width_code_o      <= 3'h0;
            dots_per_char_o        <= 4'h0;
            char_width_reserved_o  <= 1'b0;
        end else begin
            vsync_active_low_o     <= next_vsync_low;
            hsync_active_low_o     <= next_hsync_low;
            expand_enable_o        <= next_expand;
            simultaneous_crt_lcd_o <= next_simultaneous;
            automap_enable_o       <= next_automap;
            single_scan_o          <= next_single_scan;
            half_frame_enable_o    <= next_half_frame;
            companion_mode_o       <= next_companion;
            lcd_active_o           <= next_lcd_active;
            char_width_code_o      <= next_code;
            dots_per_char_o        <= next_dots;
            char_width_reserved_o  <= next_reserved;
        end
    end

    // ************************************************************
    // Graphics scanline expansion
    // ************************************************************
    // The enable is looked at every cycle, so it may change mid-frame
    // without a mode reset; the phase simply restarts when it drops
    assign expand_active = sync_polarity_control[BIT_EXPAND_GFX] & gfx_mode_i;
    assign scan_edge     = scanline_i & ~scan_q;

    // Phase over each group of 16 source lines; three repeats make 19
    always_comb begin
        next_line_phase = line_phase;
        next_replicate  = 1'b0;
        if (!expand_active) begin
            next_line_phase = 5'h00;
        end else if (scan_edge) begin
            if (line_phase == EXPAND_SRC_LINES - 5'h01) begin
                next_line_phase = 5'h00;
            end else begin
                next_line_phase = line_phase + 5'h01;
            end
            // Repeat after phases 4, 9 and 14 to spread the extra lines
            next_replicate = (line_phase == 5'h04) || (line_phase == 5'h09)
                             || (line_phase == 5'h0E);
        end
    end

    // Expansion phase, line edge history and repeat pulse
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            line_phase       <= 5'h00;
            scan_q           <= 1'b0;
            replicate_line_o <= 1'b0;
        end else begin
            line_phase       <= next_line_phase;
            scan_q           <= scanline_i;
            replicate_line_o <= next_replicate;
        end
    end

endmodule : lcdext_control

// ### testbench/lcdext_control_properties.sv
module lcdext_props
    import lcdext_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic [7:0] index_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [1:0] misc_sync_pol_i,
    input wire logic       sequencer_clocking_bit0_i,
    input wire logic       gfx_mode_i,
    input wire logic [7:0] rdata_o,
    input wire logic       vsync_active_low_o,
    input wire logic       hsync_active_low_o,
    input wire logic       replicate_line_o,
    input wire logic       expand_enable_o,
    input wire logic       simultaneous_crt_lcd_o,
    input wire logic       automap_enable_o,
    input wire logic       single_scan_o,
    input wire logic       half_frame_enable_o,
    input wire logic       companion_mode_o,
    input wire logic       lcd_active_o,
    input wire logic [2:0] char_width_code_o,
    input wire logic [3:0] dots_per_char_o,
    input wire logic       char_width_reserved_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sp_q, dm_q, cc_q, rsel;
    logic [1:0] up_q;
    logic [2:0] ec;
    logic [4:0] dx;
    wire        ok = up_q[1];
    wire        ev = sp_q[5] ? sp_q[7] : misc_sync_pol_i[1];
    wire        eh = sp_q[5] ? sp_q[6] : misc_sync_pol_i[0];
    wire  [3:0] md = {dm_q[7], dm_q[5], dm_q[3], dm_q[0]};
    wire  [3:0] mo = {simultaneous_crt_lcd_o, automap_enable_o, companion_mode_o, lcd_active_o};
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Shadow registers and a settle flag after reset
    always_ff @(posedge clock_i) begin
        up_q <= rst_i ? 2'h0 : {up_q[0], 1'b1};
        if (rst_i) {sp_q, dm_q, cc_q} <= 24'h0;
        else if (wr_i && index_i == IDX_SYNC_POLARITY) sp_q <= wdata_i & MASK_SYNC_POLARITY;
        else if (wr_i && index_i == IDX_DISPLAY_MODE) dm_q <= wdata_i & MASK_DISPLAY_MODE;
        else if (wr_i && index_i == IDX_CHAR_CLOCK) cc_q <= wdata_i & MASK_CHAR_CLOCK;
    end
    // Expected width code, reserved flag with dots, and read data
    always_comb begin
        ec = cc_q[3] ? cc_q[2:0] : {cc_q[2:1], sequencer_clocking_bit0_i};
        case (ec)
            3'h0: dx = 5'h09;
            3'h1: dx = 5'h08;
            3'h2: dx = 5'h04;
            3'h4: dx = 5'h0B;
            default: dx = 5'h18;
        endcase
        rsel = index_i == IDX_SYNC_POLARITY ? sp_q : index_i == IDX_DISPLAY_MODE ? dm_q
             : index_i == IDX_CHAR_CLOCK ? cc_q : 8'h00;
    end
    vsync_pol_a: assert property (ok |-> vsync_active_low_o == $past(ev)) else $error("vsync");
    hsync_pol_a: assert property (ok |-> hsync_active_low_o == $past(eh)) else $error("hsync");
    expand_copy_a: assert property (ok |-> expand_enable_o == $past(sp_q[4])) else $error("expand");
    gate_off_a: assert property ((!sp_q[4] || !gfx_mode_i) [*4] |-> !replicate_line_o)
        else $error("replicate while off");
    mode_bits_a: assert property (ok |-> mo == $past(md)) else $error("mode bits");
    scan_ctl_a: assert property (ok |-> single_scan_o == $past(dm_q[4])
        && half_frame_enable_o == !single_scan_o) else $error("scan control");
    width_code_a: assert property (ok |-> char_width_code_o == $past(ec)) else $error("code");
    dots_map_a: assert property (ok |-> {char_width_reserved_o, dots_per_char_o} == $past(dx))
        else $error("dots");
    read_back_a: assert property (rd_i |=> rdata_o == $past(rsel)) else $error("read data");
    cover property (replicate_line_o);
    cover property (wr_i && rd_i);
    cover property (char_width_reserved_o);
endmodule : lcdext_props

bind lcdext_control lcdext_props chk_u (.*);

// ### testbench/lcdext_panel_model.sv
module lcdext_panel_model #(
    parameter int LINE_CYCLES = 8
) (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic replicate_line_i,
    output logic      scanline_o,
    output int        rep_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc;
    // Line pulse once per line period and a tally of repeated lines
    always @(posedge clock_i) begin
        cyc <= (rst_i || cyc == LINE_CYCLES - 1) ? 0 : cyc + 1;
        scanline_o <= !rst_i && cyc == 0;
        rep_count_o <= rst_i ? 0 : rep_count_o + int'(replicate_line_i);
    end
endmodule : lcdext_panel_model

// ### testbench/lcdext_control_tb_top.sv
module lcdext_control_tb_top;
    import lcdext_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0;
    logic        sequencer_clocking_bit0_i = 1'b0, gfx_mode_i = 1'b0, scanline_i;
    logic [1:0]  misc_sync_pol_i = 2'h0;
    logic [7:0]  index_i = 8'h00, wdata_i = 8'h00, rdata_o, a, d;
    logic [7:0]  sh [4] = '{default: 8'h00};
    logic [7:0]  mk [4] = '{MASK_SYNC_POLARITY, MASK_DISPLAY_MODE, MASK_CHAR_CLOCK, 8'h00};
    logic [7:0]  expq [$];
    logic        vsync_active_low_o, hsync_active_low_o, replicate_line_o, expand_enable_o;
    logic        simultaneous_crt_lcd_o, automap_enable_o, single_scan_o, half_frame_enable_o;
    logic        companion_mode_o, lcd_active_o, char_width_reserved_o;
    logic [2:0]  char_width_code_o;
    logic [3:0]  dots_per_char_o;
    int          seed = 16, n_fail = 0, checks = 0, cyc = 0, r0, rep_count;
    wire  [16:0] outs = {vsync_active_low_o, hsync_active_low_o, expand_enable_o,
        simultaneous_crt_lcd_o, automap_enable_o, single_scan_o, half_frame_enable_o,
        companion_mode_o, lcd_active_o, char_width_code_o, dots_per_char_o,
        char_width_reserved_o};

    lcdext_control dut_u (.*);
    lcdext_panel_model #(.LINE_CYCLES(8)) panel_u (.clock_i(clock_i), .rst_i(rst_i),
        .replicate_line_i(replicate_line_o), .scanline_o(scanline_i), .rep_count_o(rep_count));

    // Clock and timeout
    always #4 clock_i = !clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            summarize();
        end
    end
    // Read data monitor takes the oldest note
    always @(posedge clock_i) rd_q <= rd_i;
    always @(negedge clock_i) if (rd_q) check_rd(rdata_o, expq.pop_front());

    task automatic check_rd(input logic [7:0] g, e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: read data got %h expected %h", $time, g, e);
        end
    endtask : check_rd

    task automatic check_outs(input logic [16:0] g, e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: controls got %h expected %h", $time, g, e);
        end
    endtask : check_outs

    task automatic check_count(input logic [15:0] g, e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: repeats got %h expected %h", $time, g, e);
        end
    endtask : check_count

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Expected control outputs from the shadow copies
    function automatic logic [16:0] expv();
        logic [2:0] k;
        k = sh[2][3] ? sh[2][2:0] : {sh[2][2:1], sequencer_clocking_bit0_i};
        expv = {sh[0][5] ? sh[0][7:6] : misc_sync_pol_i, sh[0][4], sh[1][7], sh[1][5],
            sh[1][4], !sh[1][4], sh[1][3], sh[1][0], k, k == 3'h0 ? 4'h9 : k == 3'h1 ? 4'h8
            : k == 3'h2 ? 4'h4 : k == 3'h4 ? 4'hB : 4'h8, (k == 3'h3) || (k > 3'h4)};
    endfunction : expv

    // One access: read always, write too when asked, then an idle cycle
    task automatic acc(input logic w, input logic [7:0] ad, wd);
        index_i = ad;
        wdata_i = wd;
        wr_i = w;
        rd_i = 1'b1;
        expq.push_back(sh[ad[1:0]]);
        @(negedge clock_i);
        wr_i = 1'b0;
        rd_i = 1'b0;
        if (w) sh[ad[1:0]] = wd & mk[ad[1:0]];
        @(negedge clock_i);
    endtask : acc

    task automatic step(input logic [7:0] ad, wd);
        acc(1'b1, ad, wd);
        acc(1'b0, ad, 8'h00);
        check_outs(outs, expv());
    endtask : step

    // Main sequence
    initial begin
        repeat (3) @(negedge clock_i);
        rst_i = 1'b0;
        for (int i = 0; i < 4; i++) acc(1'b0, 8'h7F + 8'(i), 8'h00);
        check_outs(outs, expv());
        $display("reset test done");
        for (int i = 0; i < 60; i++) begin
            a = 8'h7F + 8'($random(seed) & 3);
            d = 8'($random(seed));
            if (a == IDX_CHAR_CLOCK) d[7:4] = 4'h0;
            misc_sync_pol_i = 2'($random(seed));
            sequencer_clocking_bit0_i = 1'($random(seed));
            step(a, d);
        end
        for (int k = 0; k < 16; k++) step(IDX_CHAR_CLOCK, 8'(k));
        $display("register test done");
        for (int k = 0; k < 4; k++) begin
            gfx_mode_i = k[1];
            step(IDX_SYNC_POLARITY, {3'h0, k[0], 4'h0});
            @(posedge scanline_i);
            repeat (5) @(negedge clock_i);
            r0 = rep_count;
            repeat (32) @(posedge scanline_i);
            repeat (5) @(negedge clock_i);
            check_count(16'(rep_count - r0), k == 3 ? 16'h0006 : 16'h0000);
        end
        $display("expansion test done");
        summarize();
    end
endmodule : lcdext_control_tb_top
